// [mslw_pkg.sv]
// Package with register map, reset values and timing for the scheduler.
package mslw_pkg;
    // Register offsets on the byte register port.
    localparam logic [7:0] WAKE_INTERVAL_OFS   = 8'h08;
    localparam logic [7:0] PROX_RATE_OFS       = 8'h0A;
    localparam logic [7:0] LIGHT_LOW_LO_OFS    = 8'h0B;
    localparam logic [7:0] LIGHT_LOW_HI_OFS    = 8'h0C;
    localparam logic [7:0] LIGHT_HIGH_LO_OFS   = 8'h0D;
    localparam logic [7:0] LIGHT_HIGH_HI_OFS   = 8'h0E;
    // Every register of this block resets to zero.
    localparam logic [7:0] REG_RESET           = 8'h00;
    // Compressed code layout: exponent in the upper nibble.
    localparam int         EXP_MSB             = 7;
    localparam int         EXP_LSB             = 4;
    localparam int         MANT_MSB            = 3;
    // Rate codes with fixed expansions.
    localparam logic [7:0]  RATE_OFF_CODE      = 8'h00;
    localparam logic [7:0]  RATE_TEN_CODE      = 8'h32;
    localparam logic [15:0] RATE_TEN_VALUE     = 16'h000A;
    // Wake time base: one interval unit lasts 31.25 us.
    localparam int         TICK_PS             = 31250000 / 1000;
    localparam int         UNIT_PS_X1000       = 31250000;
    localparam int         CLK_PS              = 20000;
    localparam int         TICK_CYCLES         = UNIT_PS_X1000 / CLK_PS;
    localparam int         TICK_CNT_W          = 11;
endpackage : mslw_pkg

// [mslw_expand.sv]
// Expander from an 8-bit compressed code to a 16-bit integer.
`timescale 1ns/1ns
`default_nettype none
module mslw_expand
    import mslw_pkg::*;
(
    input  wire logic [7:0]  code,   // Compressed code.
    output logic      [15:0] value   // Expanded 16-bit value.
);
    // Floating form: value = ({1,mantissa} << exponent) >> 4.
    always_comb begin
        logic [31:0] wide;
        wide = 32'h0;
        wide = {27'h0, 1'b1, code[MANT_MSB:0]} << code[EXP_MSB:EXP_LSB];
        if (code == RATE_OFF_CODE) begin
            value = 16'h0000;
        end else if (code == RATE_TEN_CODE) begin
            value = RATE_TEN_VALUE; // Fixed point for this code.
        end else begin
            value = wide[19:4]; // Floating expansion of the code.
        end
    end
endmodule // mslw_expand
`default_nettype wire

// [mslw_top.sv]
// Measurement scheduler and ambient-light threshold window.
//
// Summary of operation
// - Proximity rate code expands to 16-bit multiplier.
// - Code zero stops autonomous proximity measurements.
// - Code 0x08 measures at every wake-up.
// - Code 0x32 measures every tenth wake-up.
// - Code 0x69 measures every hundredth wake-up.
// - Low and high thresholds form light window.
// - Offset 0x0B holds lower threshold low byte.
// - Offset 0x0C holds lower threshold high byte.
// - Offset 0x0D holds upper threshold low byte.
// - All these registers reset to zero.
// - Early revisions read thresholds as compressed codes.
// - Wake interval is expanded code times 31.25us.
// - Wake code zero stops oscillator and autonomy.
// - Offset 0x0E holds upper threshold high byte.
`timescale 1ns/1ns
`default_nettype none
module mslw_top
    import mslw_pkg::*;
(
    input  wire logic        clk,                   // 50 MHz clock.
    input  wire logic        rst_b,                 // Sync reset, low.
    input  wire logic        reg_wr,                // Register write strobe.
    input  wire logic        reg_rd,                // Register read strobe.
    input  wire logic [7:0]  reg_addr,              // Register offset.
    input  wire logic [7:0]  reg_wdata,             // Write data.
    output logic      [7:0]  reg_rdata,             // Read data.
    input  wire logic        early_revision,        // Compressed thresholds.
    input  wire logic        force_prox,            // Forced measurement.
    input  wire logic        light_valid,           // Light result strobe.
    input  wire logic        light_use_ir,          // Compare infrared.
    input  wire logic [15:0] visible_light_result,  // Visible result.
    input  wire logic [15:0] infrared_light_result, // Infrared result.
    output logic             osc_run,               // Oscillator running.
    output logic             wake_pulse,            // Wake-up event pulse.
    output logic             prox_meas_start,       // Proximity start pulse.
    output logic             light_event            // Window event pulse.
);
    import mslw_pkg::*;

    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CYCLES[TICK_CNT_W-1:0] - 1'b1;

    // Software registers.
    logic [7:0]  wake_interval_code;       // Wake interval code.
    logic [7:0]  proximity_rate_multiplier; // Proximity rate code.
    logic [7:0]  light_low_threshold_lo;   // Lower threshold bits 7:0.
    logic [7:0]  light_low_threshold_hi;   // Lower threshold bits 15:8.
    logic [7:0]  light_high_threshold_lo;  // Upper threshold bits 7:0.
    logic [7:0]  light_high_threshold_hi;  // Upper threshold bits 15:8.
    logic [7:0]  next_wake_interval_code;
    logic [7:0]  next_proximity_rate_multiplier;
    logic [7:0]  next_light_low_threshold_lo;
    logic [7:0]  next_light_low_threshold_hi;
    logic [7:0]  next_light_high_threshold_lo;
    logic [7:0]  next_light_high_threshold_hi;
    logic [7:0]  next_reg_rdata;

    // Schedule state.
    logic [TICK_CNT_W-1:0] tick_cnt;      // Cycles within one time unit.
    logic [15:0]           unit_cnt;      // Units within one interval.
    logic [15:0]           wake_cnt;      // Wake-ups since last proximity.
    logic [TICK_CNT_W-1:0] next_tick_cnt;
    logic [15:0]           next_unit_cnt;
    logic [15:0]           next_wake_cnt;
    logic                  next_osc_run;
    logic                  next_wake_pulse;
    logic                  next_prox_meas_start;
    logic                  next_light_event;

    // Expanded values.
    logic [15:0] wake_units;      // Interval in 31.25 us units.
    logic [15:0] prox_mult;       // Wake-ups per proximity measurement.
    logic [15:0] low_expanded;    // Lower threshold, compressed form.
    logic [15:0] high_expanded;   // Upper threshold, compressed form.
    logic [15:0] window_lower;    // Active lower threshold.
    logic [15:0] window_upper;    // Active upper threshold.
    logic [15:0] light_sample;    // Selected light result.

    mslw_expand u_wake (.code(wake_interval_code), .value(wake_units));
    mslw_expand u_prox (.code(proximity_rate_multiplier),
                        .value(prox_mult));
    mslw_expand u_low  (.code(light_low_threshold_lo),
                        .value(low_expanded));
    mslw_expand u_high (.code(light_high_threshold_lo),
                        .value(high_expanded));

    // Register writes and reads; unmapped reads return zero.
    always_comb begin
        next_wake_interval_code        = wake_interval_code;
        next_proximity_rate_multiplier = proximity_rate_multiplier;
        next_light_low_threshold_lo    = light_low_threshold_lo;
        next_light_low_threshold_hi    = light_low_threshold_hi;
        next_light_high_threshold_lo   = light_high_threshold_lo;
        next_light_high_threshold_hi   = light_high_threshold_hi;
        next_reg_rdata                 = reg_rdata;
        if (reg_wr) begin
            if (reg_addr == WAKE_INTERVAL_OFS) begin
                next_wake_interval_code = reg_wdata;
            end else if (reg_addr == PROX_RATE_OFS) begin
                next_proximity_rate_multiplier = reg_wdata;
            end else if (reg_addr == LIGHT_LOW_LO_OFS) begin
                next_light_low_threshold_lo = reg_wdata;
            end else if (reg_addr == LIGHT_LOW_HI_OFS) begin
                next_light_low_threshold_hi = reg_wdata;
            end else if (reg_addr == LIGHT_HIGH_LO_OFS) begin
                next_light_high_threshold_lo = reg_wdata;
            end else if (reg_addr == LIGHT_HIGH_HI_OFS) begin
                next_light_high_threshold_hi = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == WAKE_INTERVAL_OFS) begin
                next_reg_rdata = wake_interval_code;
            end else if (reg_addr == PROX_RATE_OFS) begin
                next_reg_rdata = proximity_rate_multiplier;
            end else if (reg_addr == LIGHT_LOW_LO_OFS) begin
                next_reg_rdata = light_low_threshold_lo;
            end else if (reg_addr == LIGHT_LOW_HI_OFS) begin
                next_reg_rdata = light_low_threshold_hi;
            end else if (reg_addr == LIGHT_HIGH_LO_OFS) begin
                next_reg_rdata = light_high_threshold_lo;
            end else if (reg_addr == LIGHT_HIGH_HI_OFS) begin
                next_reg_rdata = light_high_threshold_hi;
            end else begin
                next_reg_rdata = 8'h00;
            end
        end
    end

    // Register file flip-flops; all clear to zero on reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_interval_code        <= REG_RESET;
            proximity_rate_multiplier <= REG_RESET;
            light_low_threshold_lo    <= REG_RESET;
            light_low_threshold_hi    <= REG_RESET;
            light_high_threshold_lo   <= REG_RESET;
            light_high_threshold_hi   <= REG_RESET;
            reg_rdata                 <= 8'h00;
        end else begin
            wake_interval_code        <= next_wake_interval_code;
            proximity_rate_multiplier <= next_proximity_rate_multiplier;
            light_low_threshold_lo    <= next_light_low_threshold_lo;
            light_low_threshold_hi    <= next_light_low_threshold_hi;
            light_high_threshold_lo   <= next_light_high_threshold_lo;
            light_high_threshold_hi   <= next_light_high_threshold_hi;
            reg_rdata                 <= next_reg_rdata;
        end
    end

    // Window bounds; early parts use the low byte as a compressed code.
    always_comb begin
        if (early_revision) begin
            window_lower = low_expanded;
            window_upper = high_expanded;
        end else begin
            window_lower = {light_low_threshold_hi, light_low_threshold_lo};
            window_upper = {light_high_threshold_hi,
                            light_high_threshold_lo};
        end
        light_sample = light_use_ir ? infrared_light_result
                                    : visible_light_result;
    end

    // Wake timer, proximity divider and window compare.
    always_comb begin
        next_tick_cnt        = tick_cnt;
        next_unit_cnt        = unit_cnt;
        next_wake_cnt        = wake_cnt;
        next_wake_pulse      = 1'b0;
        next_prox_meas_start = force_prox;
        next_osc_run         = (wake_interval_code != RATE_OFF_CODE);
        if (wake_interval_code == RATE_OFF_CODE) begin
            // Oscillator stopped: timers hold cleared.
            next_tick_cnt = '0;
            next_unit_cnt = '0;
            next_wake_cnt = '0;
        end else if (tick_cnt >= TICK_LAST) begin
            next_tick_cnt = '0;
            if (unit_cnt + 16'h0001 >= wake_units) begin
                // Interval of expanded units has elapsed.
                next_unit_cnt   = 16'h0000;
                next_wake_pulse = 1'b1;
                if (prox_mult == 16'h0000) begin
                    next_wake_cnt = 16'h0000;
                end else if (wake_cnt + 16'h0001 >= prox_mult) begin
                    // Every Nth wake-up starts proximity.
                    next_wake_cnt        = 16'h0000;
                    next_prox_meas_start = 1'b1;
                end else begin
                    next_wake_cnt = wake_cnt + 16'h0001;
                end
            end else begin
                next_unit_cnt = unit_cnt + 16'h0001;
            end
        end else begin
            next_tick_cnt = tick_cnt + 1'b1;
        end
        // Event when the sample lies outside the inclusive window.
        next_light_event = light_valid &&
            ((light_sample < window_lower) ||
             (light_sample > window_upper));
    end

    // Schedule flip-flops.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_cnt        <= '0;
            unit_cnt        <= 16'h0000;
            wake_cnt        <= 16'h0000;
            osc_run         <= 1'b0;
            wake_pulse      <= 1'b0;
            prox_meas_start <= 1'b0;
            light_event     <= 1'b0;
        end else begin
            tick_cnt        <= next_tick_cnt;
            unit_cnt        <= next_unit_cnt;
            wake_cnt        <= next_wake_cnt;
            osc_run         <= next_osc_run;
            wake_pulse      <= next_wake_pulse;
            prox_meas_start <= next_prox_meas_start;
            light_event     <= next_light_event;
        end
    end
endmodule // mslw_top
`default_nettype wire

// [mslw_props.sv]
// Checker for register, schedule and light window behaviour at the ports.
`timescale 1ns/1ns
`default_nettype none
module mslw_props
    import mslw_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        early_revision,
    input wire logic        force_prox,
    input wire logic        light_valid,
    input wire logic        light_use_ir,
    input wire logic [15:0] visible_light_result,
    input wire logic [15:0] infrared_light_result,
    input wire logic        osc_run,
    input wire logic        wake_pulse,
    input wire logic        prox_meas_start,
    input wire logic        light_event
);
    logic [15:0] lo;   // Shadow of the lower bound.
    logic [15:0] hi;   // Shadow of the upper bound.
    logic [15:0] smp;  // Sample the window is applied to.
    assign smp = light_use_ir ? infrared_light_result : visible_light_result;
    // Shadow bounds follow every threshold register write.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lo <= 16'h0000;
            hi <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                LIGHT_LOW_LO_OFS:  lo[7:0]  <= reg_wdata;
                LIGHT_LOW_HI_OFS:  lo[15:8] <= reg_wdata;
                LIGHT_HIGH_LO_OFS: hi[7:0]  <= reg_wdata;
                LIGHT_HIGH_HI_OFS: hi[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Two idle cycles of the oscillator.
    sequence s_idle;
        !osc_run ##1 !osc_run;
    endsequence
    // A plain read of the lower bound low byte.
    sequence s_rd_lo;
        reg_rd && !reg_wr && reg_addr == LIGHT_LOW_LO_OFS;
    endsequence
    property p_off;
        s_idle |-> !wake_pulse;
    endproperty
    a_off: assert property (p_off) else $error("wake while stopped");
    // The code lands one edge after the write, the level one edge later.
    property p_osc;
        reg_wr && reg_addr == WAKE_INTERVAL_OFS |->
            ##2 osc_run == |$past(reg_wdata, 2);
    endproperty
    a_osc: assert property (p_osc) else $error("osc level");
    property p_prox;
        prox_meas_start && !$past(force_prox) |-> wake_pulse;
    endproperty
    a_prox: assert property (p_prox) else $error("start off wake");
    property p_force;
        force_prox |=> prox_meas_start;
    endproperty
    a_force: assert property (p_force) else $error("forced start");
    property p_win;
        light_valid && !early_revision |=>
            light_event == $past(smp < lo || smp > hi);
    endproperty
    a_win: assert property (p_win) else $error("window event");
    property p_quiet;
        !light_valid |=> !light_event;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray event");
    property p_rdlo;
        s_rd_lo |=> reg_rdata == $past(lo[7:0]);
    endproperty
    a_rdlo: assert property (p_rdlo) else $error("lower byte read");
    property p_pulse;
        wake_pulse |=> !wake_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake too long");
endmodule // mslw_props
bind mslw_top mslw_props u_props (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .early_revision(early_revision),
    .force_prox(force_prox), .light_valid(light_valid),
    .light_use_ir(light_use_ir), .visible_light_result(visible_light_result),
    .infrared_light_result(infrared_light_result), .osc_run(osc_run),
    .wake_pulse(wake_pulse), .prox_meas_start(prox_meas_start),
    .light_event(light_event));
`default_nettype wire

// [mslw_host.sv]
// Host model that drives the register port of the block.
`timescale 1ns/1ns
`default_nettype none
module mslw_host (
    input  wire logic       clk,       // Bus clock.
    output logic            reg_wr,    // Write strobe.
    output logic            reg_rd,    // Read strobe.
    output logic      [7:0] reg_addr,  // Register offset.
    output logic      [7:0] reg_wdata  // Write data.
);
    // The bus starts idle.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One access; released lines show inverted values so nothing leans on
    // them. Bounds are only written while the schedule is stopped.
    // Rates use the smallest multiplier that gives the period.
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        #2;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // mslw_host
`default_nettype wire

// [tb.sv]
// Self-checking bench for the scheduler and light window block.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mslw_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, force_prox = 1'b0, light_valid = 1'b0;
    logic light_use_ir = 1'b0, reg_wr, reg_rd, osc_run, wake_pulse, pms, lev;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_q[$];
    logic [15:0] vis = 16'h0000, ir = 16'h0000, s;
    // Edges of the full window, then edges of the compressed-code window.
    logic [15:0] bnd[8] = '{16'h0FFF, 16'h1000, 16'hC000, 16'hC001,
                            16'h0063, 16'h0064, 16'h0140, 16'h0141};
    logic [31:0] lfsr = 32'h8DEC;
    logic ev_q[$], early_rev = 1'b0;
    int num_errors = 0, samples_checked = 0;
    always #10 clk = ~clk;
    mslw_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    mslw_top dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .early_revision(early_rev), .force_prox(force_prox),
        .light_valid(light_valid), .light_use_ir(light_use_ir),
        .visible_light_result(vis), .infrared_light_result(ir),
        .osc_run(osc_run), .wake_pulse(wake_pulse),
        .prox_meas_start(pms), .light_event(lev));
    // Next value of the stimulus shift register.
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        num_errors++;
    endtask
    task automatic chk_byte(input logic [7:0] g, e, input string m);
        samples_checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_cnt(input int g, e, input string m);
        samples_checked++;
        if (g != e) fail(m);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.access(1'b1, a, d);
    endtask
    // A read notes its expected byte before the access is made.
    task automatic rd(input logic [7:0] a, e);
        rd_q.push_back(e);
        u_host.access(1'b0, a, 8'h00);
    endtask
    // Counts starts over n wakes and checks that wakes lie u units apart.
    task automatic run_wakes(input int n, ep, u);
        int w, p, last, i;
        w = 0;
        p = 0;
        last = 0;
        for (i = 0; i < n * u * 1700 + 2000 && w < n; i++) begin
            @(posedge clk);
            #1;
            if (pms) p++;
            if (wake_pulse) begin
                if (w > 0) begin
                    chk_cnt(i - last, u * TICK_CYCLES, "wake gap");
                end
                w++;
                last = i;
            end
        end
        if (w < n) begin
            fail("no wake");
            report_and_stop();
        end
        chk_cnt(p, ep, "start count");
    endtask
    // Watches the outputs just after the edge that took each request; the
    // request still stands then, and its one-cycle answer has just landed.
    always @(posedge clk) begin
        #1;
        if (reg_rd === 1'b1) begin
            chk_byte(reg_rdata, rd_q.pop_front(), "read");
        end
        if (light_valid === 1'b1) begin
            chk_byte(lev, ev_q.pop_front(), "event");
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #2;
        rst_b = 1'b1;
        for (int a = 8; a <= 14; a++) rd(a[7:0], 8'h00);
        for (int a = 10; a <= 14; a++) wr(a[7:0], 8'h5A + a[7:0]);
        for (int a = 9; a <= 14; a++)
            rd(a[7:0], a == 9 ? 8'h00 : 8'h5A + a[7:0]);
        wr(LIGHT_LOW_LO_OFS, 8'h00);
        wr(LIGHT_LOW_HI_OFS, 8'h10);
        wr(LIGHT_HIGH_LO_OFS, 8'h00);
        wr(LIGHT_HIGH_HI_OFS, 8'hC0);
        for (int k = 0; k < 24; k++) begin
            lfsr = next_rand(lfsr);
            s = (k < 4) ? bnd[k] : lfsr[15:0];
            @(posedge clk);
            #2;
            light_valid = 1'b1;
            light_use_ir = lfsr[16];
            vis = lfsr[16] ? ~s : s;
            ir = lfsr[16] ? s : ~s;
            ev_q.push_back(s < 16'h1000 || s > 16'hC000);
        end
        @(posedge clk);
        #2;
        light_valid = 1'b0;
        // Early parts: the low bytes are compressed codes for 100 and 320.
        wr(LIGHT_LOW_LO_OFS, 8'h69);
        wr(LIGHT_HIGH_LO_OFS, 8'h84);
        for (int k = 4; k < 9; k++) begin
            @(posedge clk);
            #2;
            early_rev = (k < 8);
            light_valid = (k < 8);
            light_use_ir = 1'b1;
            ir = bnd[k[2:0]];
            if (k < 8) begin
                ev_q.push_back(ir < 16'h0064 || ir > 16'h0140);
            end
        end
        wr(PROX_RATE_OFS, 8'h08);
        wr(WAKE_INTERVAL_OFS, 8'h08);
        // The oscillator level follows one cycle after the code lands.
        @(posedge clk);
        #2;
        chk_byte(osc_run, 8'h01, "osc on");
        run_wakes(3, 3, 1);
        wr(PROX_RATE_OFS, RATE_TEN_CODE);
        run_wakes(20, 2, 1);
        // Two units a wake and a hundred wakes a start: none within six.
        wr(PROX_RATE_OFS, 8'h69);
        wr(WAKE_INTERVAL_OFS, 8'h10);
        run_wakes(6, 0, 2);
        wr(PROX_RATE_OFS, RATE_OFF_CODE);
        run_wakes(5, 0, 2);
        wr(WAKE_INTERVAL_OFS, 8'h00);
        @(posedge clk);
        #2;
        chk_byte(osc_run, 8'h00, "osc off");
        @(posedge clk);
        #2;
        force_prox = 1'b1;
        @(posedge clk);
        #2;
        force_prox = 1'b0;
        chk_byte(pms, 8'h01, "forced start");
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
